// ---- bench/rdd_core_props.sv ----
`timescale 1ns/1ps
module rdd_core_props import rdd_pkg::*; (
	input wire logic           clk_sys,
	input wire logic           reset,
	input wire logic           spi_clk,
	input wire logic           spi_cs_n,
	input wire logic           spi_si,
	input wire logic           spi_so_o,
	input wire logic           spi_so_oe,
	input wire logic [NCH-1:0] direct_channel_input,
	input wire logic [NCH-1:0] overload_det,
	input wire logic [NCH-1:0] gnd_level_det,
	input wire logic [NCH-1:0] open_level_det,
	input wire logic [NCH-1:0] thermal_shutdown_temp,
	input wire logic [NCH-1:0] clamp_det,
	input wire logic [NCH-1:0] channel_on,
	input wire logic [NCH-1:0] diag_current_en,
	input wire logic           standby
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Slack covers input sync and registered stage drive
	localparam int OVL_MAX = OVL_DELAY_CYC + 6;
	localparam int HOT_MAX = INT_FILT_CYC + 6;
	logic [11:0] ovl_r;
	logic [11:0] hot_r;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ovl_r <= 12'h000;
			hot_r <= 12'h000;
		end else begin
			ovl_r <= (channel_on[0] && overload_det[0]) ? ovl_r + 12'h001 : 12'h000;
			hot_r <= (channel_on[0] && thermal_shutdown_temp[0]) ? hot_r + 12'h001 : 12'h000;
		end
	end
	sequence s_cut;
		$fell(channel_on[0]) && overload_det[0];
	endsequence
	sequence s_stay;
		!channel_on[0] [*8];
	endsequence
	AST_OE: assert property (spi_so_oe == !spi_cs_n) else $error("so enable off select");
	AST_STBY_OFF: assert property (standby |-> channel_on == 8'h00) else $error("stage on in standby");
	AST_STBY_DEN: assert property (standby |-> diag_current_en == 8'h00) else $error("currents in clear");
	AST_OVL_CUT: assert property (ovl_r <= OVL_MAX) else $error("overload not cut");
	AST_HOT_CUT: assert property (hot_r <= HOT_MAX) else $error("overtemp not cut");
	AST_LOCK: assert property (s_cut |=> s_stay) else $error("stage back on after cut");
	AST_RST_VAL: assert property ($fell(reset) |-> !standby &&
		channel_on == 8'h00 && diag_current_en == 8'hff) else $error("bad reset state");
	AST_STBY_SEL: assert property ($changed(standby) |-> spi_cs_n) else $error("mode change mid frame");
endmodule // rdd_core_props
bind rdd_core rdd_core_props u_props (.clk_sys(clk_sys), .reset(reset), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
	.spi_si(spi_si), .spi_so_o(spi_so_o), .spi_so_oe(spi_so_oe), .direct_channel_input(direct_channel_input),
	.overload_det(overload_det), .gnd_level_det(gnd_level_det), .open_level_det(open_level_det),
	.thermal_shutdown_temp(thermal_shutdown_temp), .clamp_det(clamp_det), .channel_on(channel_on),
	.diag_current_en(diag_current_en), .standby(standby));

// ---- bench/rdd_host.sv ----
`timescale 1ns/1ps
module rdd_host (
	output logic      spi_clk,
	output logic      spi_cs_n,
	output logic      spi_si,
	input  wire logic spi_so_o
);
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end
	// Master side: n bits from tx[n-1] down, first 17 answer bits kept
	task automatic xfer(input logic [31:0] tx, input int n, output logic [16:0] rx);
		spi_si = tx[n-1];
		spi_cs_n = 1'b0;
		#300 rx[16] = spi_so_o;
		for (int i = n-1; i >= 0; i--) begin
			spi_clk = 1'b1;
			#10 spi_si = tx[i];
			#70 if (n-1-i < 16) rx[15-(n-1-i)] = spi_so_o;
			spi_clk = 1'b0;
			#80;
		end
		#220 spi_cs_n = 1'b1;
		spi_si = ~spi_si;
		// Stray clock while deselected must be ignored
		#100 spi_clk = 1'b1;
		#80 spi_clk = 1'b0;
		#300;
	endtask
endmodule // rdd_host

// ---- bench/relay_driver_spi_diagnosis_tb.sv ----
`timescale 1ns/1ps
module relay_driver_spi_diagnosis_tb import rdd_pkg::*;;
	logic           clk_sys = 1'b0;
	logic           reset = 1'b1;
	logic           spi_clk, spi_cs_n, spi_si, spi_so_o, spi_so_oe, stby;
	logic [NCH-1:0] din = '0, ovl = '0, gnd = '0, opn = '0, hot = '0, clamp = '0, chon, den;
	logic [16:0]    rx;
	logic [15:0]    cmd;
	logic           so_pin;
	int             failures = 0, compares = 0, seed = 87926, cyc = 0;
	always #12.5 clk_sys = ~clk_sys;
	// Released line shows the opposite level, so a late enable is caught
	assign so_pin = spi_so_oe ? spi_so_o : ~spi_so_o;
	rdd_host u_rdd_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so_o(so_pin));
	rdd_core u_rdd_core (.clk_sys(clk_sys), .reset(reset), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
		.spi_si(spi_si), .spi_so_o(spi_so_o), .spi_so_oe(spi_so_oe), .direct_channel_input(din),
		.overload_det(ovl), .gnd_level_det(gnd), .open_level_det(opn), .thermal_shutdown_temp(hot),
		.clamp_det(clamp), .channel_on(chon), .diag_current_en(den), .standby(stby));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Frame then settle; command lands a few cycles after select rises
	task automatic frm(input logic [31:0] tx, input int n);
		u_rdd_host.xfer(tx, n, rx);
		repeat (12) @(negedge clk_sys);
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	function automatic logic [15:0] exp_out(input logic [15:0] c, input logic [7:0] d);
		for (int i = 0; i < NCH; i++) begin
			exp_out[i] = c[2*i+:2] == MODE_ON || (c[2*i+:2] == MODE_IN && d[i]);
			exp_out[8+i] = c[2*i+:2] == MODE_OFF || (c[2*i+:2] == MODE_IN && !d[i]);
		end
	endfunction
	////////////////////////////////////////////////////////////////
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			test_done();
		end
	end
	initial begin
		wt(2);
		reset = 1'b0;
		wt(3);
		frm(32'h0, 16);
		chk("err_flag", rx[16], 16'h1);
		chk("diag", rx[15:0], DIAG_RST);
		chk("stby", stby, 16'h1);
		chk("den", den, 16'h0);
		frm(32'h7fff, 16);
		chk("err_flag", rx[16], 16'h1);
		chk("stby", stby, 16'h0);
		frm(32'h7fff, 16);
		chk("err_flag", rx[16], 16'h0);
		$display("test standby done");
		frm(32'haaaa, 12);
		chk("on", chon, 16'h0);
		frm(32'h3cfffa, 24);
		chk("on", chon, 16'h3);
		frm(32'h1aaaa, 17);
		chk("on", chon, 16'h3);
		$display("test count done");
		for (int k = 0; k < 8; k++) begin
			cmd = 16'($random(seed));
			for (int i = 0; i < NCH; i++) if (cmd[2*i+:2] == MODE_CLEAR) cmd[2*i+:2] = MODE_OFF;
			din = 8'($random(seed));
			frm({16'h0, cmd}, 16);
			chk("diag", rx[15:0], 16'hffff);
			chk("out", {den, chon}, exp_out(cmd, din));
			gnd = 8'(exp_out(cmd, din)) & 8'($random(seed));
		end
		gnd = '0;
		$display("test modes done");
		frm(32'hfffe, 16);
		chk("err_si", rx[16], 16'h1);
		ovl[0] = 1'b1;
		wt(500);
		chk("cut", chon, 16'h0);
		ovl[0] = 1'b0;
		frm(32'hfffe, 16);
		chk("code", rx[1:0], FC_BATT);
		chk("lock", chon, 16'h0);
		frm(32'hffff, 16);
		gnd[0] = 1'b1;
		wt(1300);
		frm(32'hfffc, 16);
		chk("code", rx[1:0], FC_BATT);
		frm(32'hffff, 16);
		chk("code", rx[1:0], FC_OK);
		wt(1300);
		frm(32'hffff, 16);
		chk("code", rx[1:0], FC_GND);
		gnd[0] = 1'b0;
		opn[0] = 1'b1;
		wt(1300);
		frm(32'hfffc, 16);
		chk("code", rx[1:0], FC_GND);
		frm(32'hffff, 16);
		wt(900);
		frm(32'hffff, 16);
		chk("code", rx[1:0], FC_OK);
		wt(400);
		frm(32'hfffc, 16);
		chk("code", rx[1:0], FC_OPEN);
		opn[0] = 1'b0;
		$display("test faults done");
		frm(32'hffff, 16);
		hot[0] = 1'b1;
		wt(60);
		frm(32'hffff, 16);
		chk("code", rx[1:0], FC_OK);
		clamp[0] = 1'b1;
		wt(5);
		hot[0] = 1'b0;
		clamp[0] = 1'b0;
		frm(32'hfffc, 16);
		chk("code", rx[1:0], FC_BATT);
		frm(32'hfffe, 16);
		chk("on", chon, 16'h1);
		hot[0] = 1'b1;
		wt(60);
		chk("hot", chon, 16'h0);
		hot[0] = 1'b0;
		frm(32'hfffe, 16);
		chk("code", rx[1:0], FC_BATT);
		chk("lock", chon, 16'h0);
		$display("test thermal done");
		test_done();
	end
endmodule // relay_driver_spi_diagnosis_tb

// ---- shared/rdd_pkg.sv ----
package rdd_pkg;

	// Channel count and word layout
	localparam int NCH    = 8;
	localparam int WORD_W = 16;
	localparam int SNAP_W = 17;
	localparam int ERR_BIT = 16;

	// Per-channel mode field, two bits each
	localparam logic [1:0] MODE_CLEAR = 2'h0;
	localparam logic [1:0] MODE_IN    = 2'h1;
	localparam logic [1:0] MODE_ON    = 2'h2;
	localparam logic [1:0] MODE_OFF   = 2'h3;

	// Per-channel fault codes, high bit first
	localparam logic [1:0] FC_OK   = 2'h3;
	localparam logic [1:0] FC_BATT = 2'h2;
	localparam logic [1:0] FC_OPEN = 2'h1;
	localparam logic [1:0] FC_GND  = 2'h0;

	// Values after reset
	localparam logic [WORD_W-1:0] CMD_RST  = 16'hffff;
	localparam logic [WORD_W-1:0] DIAG_RST = 16'hffff;

	// Timing
	localparam int CLK_KHZ       = 40000;
	localparam int DIAG_FILT_US  = 30;
	localparam int OVL_DELAY_US  = 11;
	localparam int INT_FILT_NS   = 1000;
	localparam int DIAG_FILT_CYC = (DIAG_FILT_US * CLK_KHZ + 999) / 1000;
	localparam int OVL_DELAY_CYC = (OVL_DELAY_US * CLK_KHZ + 999) / 1000;
	localparam int INT_FILT_CYC  = (INT_FILT_NS * CLK_KHZ + 999999) / 1000000;
	localparam int CNT_W         = $clog2(DIAG_FILT_CYC + 1);

	localparam logic [CNT_W-1:0] DIAG_FILT_CNT = CNT_W'(DIAG_FILT_CYC);
	localparam logic [CNT_W-1:0] OVL_DELAY_CNT = CNT_W'(OVL_DELAY_CYC);
	localparam logic [CNT_W-1:0] INT_FILT_CNT  = CNT_W'(INT_FILT_CYC);
	localparam logic [CNT_W-1:0] CNT_ONE       = CNT_W'(1);

	// Serial frame bookkeeping
	localparam logic [2:0] BITS_ONE  = 3'h1;
	localparam logic [2:0] BITS_LAST = 3'h7;
	localparam logic [1:0] BLK_MIN   = 2'h2;

	typedef struct packed {
		logic                          cs_d;
		logic                          tgl_start;
		logic                          frame_error_flag;
		logic                          stby;
		logic [WORD_W-1:0]             cmd;
		logic [SNAP_W-1:0]             snap;
		logic [NCH-1:0][1:0]           code;
		logic [NCH-1:0]                lock;
		logic [NCH-1:0]                hold;
		logic [NCH-1:0]                on;
		logic [NCH-1:0]                den;
		logic [NCH-1:0][CNT_W-1:0]     off_cnt;
		logic [NCH-1:0][CNT_W-1:0]     ovl_cnt;
		logic [NCH-1:0][CNT_W-1:0]     tmp_cnt;
	} rdd_state_t;

endpackage

// ---- src/rdd_core.sv ----
`timescale 1ns/1ps
// Summary of operation
// RQ1: Battery short checked only while stage on
// RQ2: Ground and open checks only while off
// RQ3: Hot while on latches fault, stage off
// RQ4: Hot while clamping latches, locked until clear
// RQ5: Hot off without clamp: no entry, hold
// RQ6: Clear mode: no diagnosis, currents off
// RQ7: Two-bit fault code per channel
// RQ8: Ground replaces open, open never replaces ground
// RQ9: Ground/open latched after 30 us filter
// RQ10: Every fault filtered before storing; hot while clamping is stored unfiltered
// RQ11: Overload: off after delay, latch, lock
// RQ12: Battery short overwrites stored open/ground
// RQ13: Battery code blocks open/ground until clear
// RQ14: Host clears all channels after power-up
// RQ15: Sample input falling, drive output rising
// RQ16: Accept only multiple of 8, at least 16
// RQ17: Chip select high: ignore clock, output off
// RQ18: Chip select fall loads diagnosis word
// RQ19: Before first rise output is error OR input
// RQ20: Host keeps clock low at select edges
// RQ21: Most significant bit first both ways
// RQ22: Standby resets serial protocol state; code only sets the frame error flag
// RQ23: Codes 11 ok, 10 battery/hot, 01 open, 00 ground
// RQ24: Mode field per channel, reset all ones
// RQ25: Clear mode clears faults; all clear is standby
module rdd_core import rdd_pkg::*; (
	input  wire logic           clk_sys,
	input  wire logic           reset,
	input  wire logic           spi_clk,
	input  wire logic           spi_cs_n,
	input  wire logic           spi_si,
	output logic                spi_so_o,
	output logic                spi_so_oe,
	input  wire logic [NCH-1:0] direct_channel_input,
	input  wire logic [NCH-1:0] overload_det,
	input  wire logic [NCH-1:0] gnd_level_det,
	input  wire logic [NCH-1:0] open_level_det,
	input  wire logic [NCH-1:0] thermal_shutdown_temp,
	input  wire logic [NCH-1:0] clamp_det,
	output logic      [NCH-1:0] channel_on,
	output logic      [NCH-1:0] diag_current_en,
	output logic                standby
);

	localparam int SYNC_W = 2 + 6 * NCH;

	////////////////////////////////////////////////////////////////////////////
	// Link domain: receive on falling edge

	logic [WORD_W-1:0] rx_r;
	logic [2:0]        bits_r;
	logic [1:0]        blk_r;
	logic              n_tgl_r;
	logic              p_tgl_r;
	logic              p_started_r;
	logic              so_r;
	logic [WORD_W-2:0] tx_r;

	// Clock edges while select is high are ignored; only selected edges shift and count
	always_ff @(negedge spi_clk or posedge reset) begin
		if (reset) begin
			rx_r    <= '0;
			bits_r  <= '0;
			blk_r   <= '0;
			n_tgl_r <= 1'b0;
		end else if (!spi_cs_n) begin // see RQ17
			rx_r <= {rx_r[WORD_W-2:0], spi_si}; // see RQ15 see RQ21
			if (n_tgl_r != p_tgl_r) begin
				// First falling edge of the frame restarts the count
				n_tgl_r <= p_tgl_r;
				bits_r  <= BITS_ONE;
				blk_r   <= '0;
			end else begin
				bits_r <= bits_r + BITS_ONE;
				if (bits_r == BITS_LAST && blk_r != BLK_MIN) begin
					blk_r <= blk_r + 2'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link domain: transmit on rising edge

	rdd_state_t s_r;
	rdd_state_t s_nxt;

	// Frame marker survives the select-driven reset below
	always_ff @(posedge spi_clk or posedge reset) begin
		if (reset) begin
			p_tgl_r <= 1'b0;
		end else if (!spi_cs_n && !p_started_r) begin
			p_tgl_r <= ~p_tgl_r;
		end
	end

	// Snapshot is frozen before the first rising edge: lead time exceeds sync delay
	always_ff @(posedge spi_clk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			p_started_r <= 1'b0;
			so_r        <= 1'b0;
			tx_r        <= '0;
		end else if (!p_started_r) begin
			p_started_r <= 1'b1;
			so_r        <= s_r.snap[WORD_W-1]; // see RQ18 see RQ21
			tx_r        <= s_r.snap[WORD_W-2:0];
		end else begin
			// Bits beyond the word are the input delayed by one word, for chaining
			so_r <= tx_r[WORD_W-2]; // see RQ15
			tx_r <= {tx_r[WORD_W-3:0], rx_r[0]};
		end
	end

	// Pin-level select drives the enable; no clock needed to release the line
	assign spi_so_oe = ~spi_cs_n; // see RQ17
	assign spi_so_o  = p_started_r ? so_r : (s_r.snap[ERR_BIT] | spi_si); // see RQ19

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [SYNC_W-1:0] sync_q;
	logic              cs_s;
	logic              tgl_s;
	logic [NCH-1:0]    din_s;
	logic [NCH-1:0]    ovl_s;
	logic [NCH-1:0]    gnd_s;
	logic [NCH-1:0]    opn_s;
	logic [NCH-1:0]    hot_s;
	logic [NCH-1:0]    clp_s;

	rdd_sync #(
		.W    (SYNC_W),
		.INIT (SYNC_W'(1))
	) u_sync (
		.clk_sys (clk_sys),
		.reset   (reset),
		.d       ({clamp_det, thermal_shutdown_temp, open_level_det, gnd_level_det,
		           overload_det, direct_channel_input, n_tgl_r, spi_cs_n}),
		.q       (sync_q)
	);

	assign cs_s  = sync_q[0];
	assign tgl_s = sync_q[1];
	assign din_s = sync_q[2+0*NCH +: NCH];
	assign ovl_s = sync_q[2+1*NCH +: NCH];
	assign gnd_s = sync_q[2+2*NCH +: NCH];
	assign opn_s = sync_q[2+3*NCH +: NCH];
	assign hot_s = sync_q[2+4*NCH +: NCH];
	assign clp_s = sync_q[2+5*NCH +: NCH];

	////////////////////////////////////////////////////////////////////////////
	// System domain: frames, command word, fault latching

	always_comb begin
		logic [1:0] mode;
		logic       want;
		logic       frame_ok;
		logic       all_clear;
		mode      = MODE_OFF;
		want      = 1'b0;
		frame_ok  = 1'b0;
		all_clear = 1'b0;
		s_nxt    = s_r;
		s_nxt.cs_d = cs_s;

		// Select fall: remember frame marker to tell whether any clock came
		if (!cs_s && s_r.cs_d) begin
			s_nxt.tgl_start = tgl_s;
		end

		// Select rise: receive state is quiet because the clock is parked low
		if (cs_s && !s_r.cs_d) begin // see RQ20
			frame_ok = (tgl_s != s_r.tgl_start) && (bits_r == '0) && (blk_r == BLK_MIN); // see RQ16
			if (frame_ok) begin
				s_nxt.cmd              = rx_r;
				s_nxt.frame_error_flag = 1'b0;
			end
		end

		for (int i = 0; i < NCH; i++) begin
			mode = s_r.cmd[2*i +: 2]; // see RQ24
			want = (mode == MODE_ON) || (mode == MODE_IN && din_s[i]);
			if (mode == MODE_CLEAR) begin
				// Faults cleared; lock released only once the cause is gone
				s_nxt.code[i]    = FC_OK; // see RQ25
				s_nxt.off_cnt[i] = '0; // see RQ6
				s_nxt.ovl_cnt[i] = '0;
				s_nxt.tmp_cnt[i] = '0;
				if (!ovl_s[i] && !hot_s[i] && !clp_s[i]) begin // see RQ4 see RQ11
					s_nxt.lock[i] = 1'b0;
				end
				s_nxt.hold[i] = hot_s[i];
			end else if (s_r.on[i]) begin
				s_nxt.off_cnt[i] = '0;
				if (ovl_s[i]) begin // see RQ1
					if (s_r.ovl_cnt[i] >= OVL_DELAY_CNT - CNT_ONE) begin
						s_nxt.code[i] = FC_BATT; // see RQ11 see RQ12
						s_nxt.lock[i] = 1'b1;
					end else begin
						s_nxt.ovl_cnt[i] = s_r.ovl_cnt[i] + CNT_ONE;
					end
				end else begin
					s_nxt.ovl_cnt[i] = '0;
				end
				if (hot_s[i]) begin
					if (s_r.tmp_cnt[i] >= INT_FILT_CNT - CNT_ONE) begin // see RQ10
						s_nxt.code[i] = FC_BATT; // see RQ3
						s_nxt.lock[i] = 1'b1;
					end else begin
						s_nxt.tmp_cnt[i] = s_r.tmp_cnt[i] + CNT_ONE;
					end
				end else begin
					s_nxt.tmp_cnt[i] = '0;
				end
			end else begin
				s_nxt.ovl_cnt[i] = '0;
				s_nxt.tmp_cnt[i] = '0;
				if (hot_s[i] && clp_s[i]) begin
					// Clamping energy makes heat urgent: latched without filtering
					s_nxt.code[i] = FC_BATT; // see RQ4
					s_nxt.lock[i] = 1'b1;
				end
				s_nxt.hold[i] = hot_s[i]; // see RQ5
				// Off-state checks only when the mode itself asks for off
				if (!want && (gnd_s[i] || opn_s[i])) begin // see RQ2
					if (s_r.off_cnt[i] >= DIAG_FILT_CNT - CNT_ONE) begin // see RQ9 see RQ10
						if (s_r.code[i] != FC_BATT) begin // see RQ13
							if (gnd_s[i]) begin
								s_nxt.code[i] = FC_GND; // see RQ8
							end else if (s_r.code[i] == FC_OK) begin
								s_nxt.code[i] = FC_OPEN; // see RQ8
							end
						end
					end else begin
						s_nxt.off_cnt[i] = s_r.off_cnt[i] + CNT_ONE;
					end
				end else begin
					s_nxt.off_cnt[i] = '0;
				end
			end
			s_nxt.on[i]  = want && !s_nxt.lock[i] && !s_nxt.hold[i];
			s_nxt.den[i] = (mode == MODE_OFF) || (mode == MODE_IN && !s_nxt.on[i]); // see RQ6
		end

		// Standby entry sets the frame error flag back to its reset value
		all_clear = 1'b1;
		for (int i = 0; i < NCH; i++) begin
			if (s_r.cmd[2*i +: 2] != MODE_CLEAR) begin
				all_clear = 1'b0;
			end
		end
		s_nxt.stby = all_clear; // see RQ25
		if (all_clear && !s_r.stby) begin
			s_nxt.frame_error_flag = 1'b1; // see RQ22 see RQ19
		end

		// Word offered to the next frame; frozen while select is low
		if (cs_s) begin
			s_nxt.snap = {s_nxt.frame_error_flag, s_nxt.code}; // see RQ7 see RQ23 see RQ18
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s_r           <= '0;
			s_r.cs_d      <= 1'b1;
			s_r.frame_error_flag <= 1'b1;
			s_r.cmd       <= CMD_RST;
			s_r.snap      <= {1'b1, DIAG_RST};
			s_r.code      <= DIAG_RST;
			s_r.den       <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign channel_on      = s_r.on;
	assign diag_current_en = s_r.den;
	assign standby         = s_r.stby;

endmodule // rdd_core

// ---- src/rdd_sync.sv ----
`timescale 1ns/1ps
module rdd_sync import rdd_pkg::*; #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	generate
		if (W < 1) begin : g_bad_width
			$error("rdd_sync width must be at least one");
		end
	endgenerate

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			meta_r <= INIT;
			q      <= INIT;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule // rdd_sync
